//--- logic/ies_pkg.sv
// shared constants and types of the interrupt entry sequencer
package ies_pkg;
    localparam int IES_ADDR_W = 16;
    localparam int IES_DATA_W = 8;
    localparam logic [7:0] IES_STACK_PAGE = 8'h01;
    localparam logic [15:0] IES_NMI_VEC = 16'hff00;
    localparam logic [15:0] IES_IRQ_VEC = 16'hff04;
    localparam logic [15:0] IES_VEC_HI_OFS = 16'h0001;
    localparam logic [7:0] IES_SP_STEP = 8'h01;
    localparam logic [15:0] IES_PC_RST = 16'h0000;
    localparam logic [7:0] IES_BYTE_RST = 8'h00;

    typedef enum logic [2:0] {
        IES_ST_IDLE = 3'b000,
        IES_ST_PUSH_HI = 3'b001,
        IES_ST_PUSH_LO = 3'b010,
        IES_ST_PUSH_PS = 3'b011,
        IES_ST_VEC_LO = 3'b100,
        IES_ST_VEC_HI = 3'b101,
        IES_ST_JUMP = 3'b110
    } ies_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic rd;
    } ies_mem_req_t;

    localparam ies_mem_req_t IES_REQ_IDLE = '{addr: 16'h0000, wdata: 8'h00, we: 1'b0, rd: 1'b0};
endpackage

//--- logic/ies_nmi_edge.sv
// falling edge catcher for the non-maskable request line
`timescale 1ns/10ps
module ies_nmi_edge
    import ies_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic nmi_n,
    input wire logic take,
    output logic pending
);
    logic prev;
    logic next_prev;
    logic next_pending;

    always_comb begin
        next_prev = nmi_n;
        // a new edge beats a clear in the same cycle
        next_pending = (prev & ~nmi_n) | (pending & ~take);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b1;
            pending <= 1'b0;
        end else begin
            prev <= next_prev;
            pending <= next_pending;
        end
    end

    a_nmi_edge_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (prev && !nmi_n) |=> pending)
        else $error("nmi falling edge not latched");
    a_nmi_low_once: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!pending && !prev && !nmi_n) |=> !pending)
        else $error("nmi held low raised a second request");
endmodule

//--- logic/ies_entry_seq.sv
// interrupt entry sequencer: recognise, stack pc and status, fetch vector, jump
//
// Behaviour
// - a low level on the maskable request input, or a falling edge on the non-maskable one, means service is wanted.
// - wait for the running instruction to finish before entry starts.
// - write pc and status to consecutive stack locations addressed by the stack pointer.
// - then read handler low and high bytes from two fixed locations.
// - put handler address on the bus and fetch from it, all automatic.
// - maskable or non-maskable request both enter the service software.
// - maskable input is level sensitive, taken when low and inhibit clear.
// - recognising an interrupt sets the inhibit flag automatically.
// - non-maskable input gives one interrupt per falling edge.
// - nothing inside masks the non-maskable input; inhibit ignores it.
`timescale 1ns/10ps
module ies_entry_seq
    import ies_pkg::*;
#(
    parameter logic [15:0] NMI_VEC = IES_NMI_VEC,
    parameter logic [15:0] IRQ_VEC = IES_IRQ_VEC,
    parameter logic [7:0] STACK_PAGE = IES_STACK_PAGE
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic irq_n,
    input wire logic nmi_n,
    input wire logic instr_done,
    input wire logic [15:0] cpu_pc,
    input wire logic [7:0] cpu_status,
    input wire logic [7:0] cpu_sp,
    input wire logic inhibit_set,
    input wire logic inhibit_clr,
    input wire logic [7:0] mem_rdata,
    output ies_mem_req_t mem_req,
    output logic busy,
    output logic pc_load,
    output logic [15:0] pc_new,
    output logic sp_load,
    output logic [7:0] sp_out,
    output logic inhibit,
    output logic entry_nmi
);
    ies_state_t state;
    ies_state_t next_state;
    ies_mem_req_t next_mem_req;
    logic next_busy;
    logic next_pc_load;
    logic [15:0] next_pc_new;
    logic next_sp_load;
    logic [7:0] next_sp_out;
    logic next_inhibit;
    logic next_entry_nmi;
    logic [15:0] save_pc;
    logic [15:0] next_save_pc;
    logic [7:0] save_ps;
    logic [7:0] next_save_ps;
    logic [7:0] vec_lo;
    logic [7:0] next_vec_lo;
    logic nmi_pend;
    logic irq_req;
    logic take;
    logic [15:0] vec_base;
    logic [15:0] handler;

    // falling edge latch for the non-maskable line
    ies_nmi_edge u_nmi_edge (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .nmi_n(nmi_n),
        .take(take & nmi_pend),
        .pending(nmi_pend)
    );

    always_comb begin
        irq_req = ~irq_n & ~inhibit;
        take = (state == IES_ST_IDLE) & instr_done & (nmi_pend | irq_req);
        vec_base = entry_nmi ? NMI_VEC : IRQ_VEC;
        handler = {mem_rdata, vec_lo};
        // hardware set wins over software clear
        next_inhibit = take | inhibit_set | (inhibit & ~inhibit_clr);
    end

    always_comb begin
        next_state = state;
        next_mem_req = IES_REQ_IDLE;
        next_busy = busy;
        next_pc_load = 1'b0;
        next_pc_new = pc_new;
        next_sp_load = 1'b0;
        next_sp_out = sp_out;
        next_entry_nmi = entry_nmi;
        next_save_pc = save_pc;
        next_save_ps = save_ps;
        next_vec_lo = vec_lo;
        unique case (state)
            IES_ST_IDLE: begin
                if (take) begin
                    next_state = IES_ST_PUSH_HI;
                    next_busy = 1'b1;
                    next_save_pc = cpu_pc;
                    next_save_ps = cpu_status;
                    next_sp_out = cpu_sp;
                    next_entry_nmi = nmi_pend;
                    next_mem_req.addr = {STACK_PAGE, cpu_sp};
                    next_mem_req.wdata = cpu_pc[15:8];
                    next_mem_req.we = 1'b1;
                end
            end
            IES_ST_PUSH_HI: begin
                next_state = IES_ST_PUSH_LO;
                next_sp_out = sp_out - IES_SP_STEP;
                next_mem_req.addr = {STACK_PAGE, next_sp_out};
                next_mem_req.wdata = save_pc[7:0];
                next_mem_req.we = 1'b1;
            end
            IES_ST_PUSH_LO: begin
                next_state = IES_ST_PUSH_PS;
                next_sp_out = sp_out - IES_SP_STEP;
                next_mem_req.addr = {STACK_PAGE, next_sp_out};
                next_mem_req.wdata = save_ps;
                next_mem_req.we = 1'b1;
            end
            IES_ST_PUSH_PS: begin
                next_state = IES_ST_VEC_LO;
                next_sp_out = sp_out - IES_SP_STEP;
                next_mem_req.addr = vec_base;
                next_mem_req.rd = 1'b1;
            end
            IES_ST_VEC_LO: begin
                next_state = IES_ST_VEC_HI;
                next_vec_lo = mem_rdata;
                next_mem_req.addr = vec_base + IES_VEC_HI_OFS;
                next_mem_req.rd = 1'b1;
            end
            IES_ST_VEC_HI: begin
                next_state = IES_ST_JUMP;
                next_pc_new = handler;
                next_pc_load = 1'b1;
                next_sp_load = 1'b1;
                next_mem_req.addr = handler;
                next_mem_req.rd = 1'b1;
            end
            IES_ST_JUMP: begin
                next_state = IES_ST_IDLE;
                next_busy = 1'b0;
            end
            default: begin
                next_state = IES_ST_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= IES_ST_IDLE;
            mem_req <= IES_REQ_IDLE;
            busy <= 1'b0;
            pc_load <= 1'b0;
            pc_new <= IES_PC_RST;
            sp_load <= 1'b0;
            sp_out <= IES_BYTE_RST;
            inhibit <= 1'b1;
            entry_nmi <= 1'b0;
            save_pc <= IES_PC_RST;
            save_ps <= IES_BYTE_RST;
            vec_lo <= IES_BYTE_RST;
        end else begin
            state <= next_state;
            mem_req <= next_mem_req;
            busy <= next_busy;
            pc_load <= next_pc_load;
            pc_new <= next_pc_new;
            sp_load <= next_sp_load;
            sp_out <= next_sp_out;
            inhibit <= next_inhibit;
            entry_nmi <= next_entry_nmi;
            save_pc <= next_save_pc;
            save_ps <= next_save_ps;
            vec_lo <= next_vec_lo;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_push_three;
        mem_req.we && mem_req.wdata == save_pc[15:8] && mem_req.addr == {STACK_PAGE, sp_out}
        ##1 mem_req.we && mem_req.wdata == save_pc[7:0]
        ##1 mem_req.we && mem_req.wdata == save_ps;
    endsequence

    sequence s_vec_fetch;
        mem_req.rd && mem_req.addr == vec_base
        ##1 mem_req.rd && mem_req.addr == vec_base + IES_VEC_HI_OFS;
    endsequence

    a_irq_level_take: assert property ((state == IES_ST_IDLE && instr_done && !irq_n && !inhibit)
        |=> state == IES_ST_PUSH_HI && busy)
        else $error("low request with inhibit clear not taken");
    a_wait_instr_end: assert property ((state == IES_ST_IDLE && !instr_done) |=> state == IES_ST_IDLE)
        else $error("entry started before instruction end");
    a_push_order: assert property ($rose(busy) |-> s_push_three)
        else $error("stack pushes wrong order or data");
    a_stack_step: assert property ((mem_req.we ##1 mem_req.we)
        |-> mem_req.addr[7:0] == $past(mem_req.addr[7:0]) - IES_SP_STEP)
        else $error("stack pointer not decremented per push");
    a_vec_after_push: assert property ($rose(busy) |-> ##3 s_vec_fetch)
        else $error("vector bytes not read from fixed locations");
    a_handler_jump: assert property ((state == IES_ST_VEC_HI) |=> pc_load && mem_req.rd
        && pc_new == {$past(mem_rdata), vec_lo} && mem_req.addr == pc_new)
        else $error("handler address not fetched");
    a_entry_length: assert property ($rose(busy) |-> busy [*6] ##1 !busy)
        else $error("entry sequence length wrong");
    a_nmi_priority: assert property ((take && nmi_pend) |=> entry_nmi)
        else $error("nmi entry not flagged");
    a_inhibit_on_take: assert property (take |=> inhibit)
        else $error("inhibit not set on recognition");
    a_nmi_unmasked: assert property ((state == IES_ST_IDLE && instr_done && nmi_pend && inhibit)
        |=> state == IES_ST_PUSH_HI)
        else $error("nmi blocked by inhibit");
endmodule

//--- tb/ies_pia_model.sv
// two peripheral adapters whose latched interrupt outputs share one pulled-up line
`timescale 1ns/10ps
module ies_pia_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [1:0] cond,
    input wire logic [1:0] en,
    input wire logic [1:0] ack,
    output logic irq_n
);
    logic [1:0] latched;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            latched <= 2'h0;
        end else begin
            latched <= (latched | (cond & en)) & ~ack;
        end
    end

    // outputs only pull low, the resistor supplies the high level
    assign irq_n = ~|(latched & en);
endmodule

//--- tb/tb.sv
// self-checking bench for the interrupt entry sequencer
`timescale 1ns/10ps
module tb;
    import ies_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic nmi_n = 1'b1;
    logic instr_done = 1'b0;
    logic [15:0] cpu_pc = 16'h0000;
    logic [7:0] cpu_status = 8'h00;
    logic [7:0] cpu_sp = 8'hff;
    logic inhibit_set = 1'b0;
    logic inhibit_clr = 1'b0;
    logic [1:0] cond = 2'h0;
    logic [1:0] en = 2'h0;
    logic [1:0] ack = 2'h0;
    logic irq_n;
    logic [7:0] mem_rdata;
    ies_mem_req_t mem_req;
    logic busy, pc_load, sp_load, inhibit, entry_nmi;
    logic [15:0] pc_new;
    logic [7:0] sp_out;
    int miscompares = 0;
    int total_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    // vector table, anything else reads a filler pattern
    assign mem_rdata = (mem_req.addr == IES_NMI_VEC) ? 8'h21 : (mem_req.addr == IES_NMI_VEC + 16'h0001) ? 8'h43 :
        (mem_req.addr == IES_IRQ_VEC) ? 8'h65 : (mem_req.addr == IES_IRQ_VEC + 16'h0001) ? 8'h87 : 8'h5a;

    ies_pia_model i_ies_pia_model (.sys_clk(sys_clk), .rst_b(rst_b), .cond(cond), .en(en), .ack(ack), .irq_n(irq_n));

    ies_entry_seq i_ies_entry_seq (.sys_clk(sys_clk), .rst_b(rst_b), .irq_n(irq_n), .nmi_n(nmi_n),
        .instr_done(instr_done), .cpu_pc(cpu_pc), .cpu_status(cpu_status), .cpu_sp(cpu_sp),
        .inhibit_set(inhibit_set), .inhibit_clr(inhibit_clr), .mem_rdata(mem_rdata), .mem_req(mem_req),
        .busy(busy), .pc_load(pc_load), .pc_new(pc_new), .sp_load(sp_load), .sp_out(sp_out),
        .inhibit(inhibit), .entry_nmi(entry_nmi));

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic entry(input logic [15:0] pc, input logic [7:0] sp, input logic [15:0] vec,
                         input logic [15:0] h, input logic is_nmi);
        cpu_pc = pc;
        cpu_sp = sp;
        cpu_status = 8'ha5;
        instr_done = 1'b1;
        step();
        instr_done = 1'b0;
        chk(busy === 1'b1 && mem_req.we === 1'b1 && mem_req.addr === {IES_STACK_PAGE, sp}, "push hi addr");
        chk(mem_req.wdata === pc[15:8] && inhibit === 1'b1, "push hi data");
        step();
        chk(mem_req.we === 1'b1 && mem_req.addr === {IES_STACK_PAGE, sp - 8'h01}, "push lo addr");
        chk(mem_req.wdata === pc[7:0], "push lo data");
        step();
        chk(mem_req.we === 1'b1 && mem_req.addr === {IES_STACK_PAGE, sp - 8'h02}, "push status addr");
        chk(mem_req.wdata === 8'ha5, "push status data");
        step();
        chk(mem_req.rd === 1'b1 && mem_req.we === 1'b0 && mem_req.addr === vec, "vector lo");
        step();
        chk(mem_req.rd === 1'b1 && mem_req.addr === vec + 16'h0001, "vector hi");
        step();
        chk(pc_load === 1'b1 && pc_new === h && mem_req.addr === h && mem_req.rd === 1'b1, "jump");
        chk(sp_load === 1'b1 && sp_out === sp - 8'h03 && entry_nmi === is_nmi, "sp and source");
        step();
        chk(busy === 1'b0 && pc_load === 1'b0 && mem_req.rd === 1'b0, "back to idle");
    endtask

    task automatic no_entry(input string msg);
        instr_done = 1'b1;
        step();
        instr_done = 1'b0;
        chk(busy === 1'b0 && mem_req.we === 1'b0, msg);
        step();
    endtask

    task automatic irq_scenario();
        cond = 2'h3;
        en = 2'h2;
        step();
        cond = 2'h0;
        chk(irq_n === 1'b0, "wired line low");
        no_entry("irq taken while inhibited");
        inhibit_clr = 1'b1;
        step();
        inhibit_clr = 1'b0;
        repeat (3) step();
        chk(busy === 1'b0, "entry without instruction end");
        entry(16'h1234, 8'hff, IES_IRQ_VEC, 16'h8765, 1'b0);
        no_entry("same irq taken twice");
        ack = 2'h2;
        step();
        ack = 2'h0;
        inhibit_clr = 1'b1;
        step();
        inhibit_clr = 1'b0;
        chk(irq_n === 1'b1, "disabled adapter drove line");
        no_entry("entry with line high");
    endtask

    task automatic nmi_scenario();
        inhibit_set = 1'b1;
        step();
        inhibit_set = 1'b0;
        nmi_n = 1'b0;
        step();
        entry(16'hbeef, 8'h02, IES_NMI_VEC, 16'h4321, 1'b1);
        no_entry("nmi held low taken again");
        nmi_n = 1'b1;
        step();
        nmi_n = 1'b0;
        cond = 2'h2;
        en = 2'h2;
        step();
        cond = 2'h0;
        inhibit_clr = 1'b1;
        step();
        inhibit_clr = 1'b0;
        entry(16'h00ff, 8'h80, IES_NMI_VEC, 16'h4321, 1'b1);
        inhibit_clr = 1'b1;
        step();
        inhibit_clr = 1'b0;
        entry(16'h5566, 8'h7d, IES_IRQ_VEC, 16'h8765, 1'b0);
    endtask

    task automatic reset_scenario();
        nmi_n = 1'b1;
        step();
        nmi_n = 1'b0;
        step();
        instr_done = 1'b1;
        step();
        instr_done = 1'b0;
        chk(busy === 1'b1 && entry_nmi === 1'b1, "nmi entry before reset");
        rst_b = 1'b0;
        #1;
        chk(busy === 1'b0 && mem_req === IES_REQ_IDLE && pc_load === 1'b0 && sp_load === 1'b0, "reset outputs");
        chk(pc_new === IES_PC_RST && sp_out === IES_BYTE_RST && inhibit === 1'b1 && entry_nmi === 1'b0, "reset values");
        nmi_n = 1'b1;
        repeat (2) step();
        rst_b = 1'b1;
        instr_done = 1'b1;
        step();
        chk(busy === 1'b0, "entry after reset without request");
        nmi_n = 1'b0;
        step();
        chk(busy === 1'b0, "entry before nmi edge was latched");
        entry(16'h0102, 8'hff, IES_NMI_VEC, 16'h4321, 1'b1);
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        chk(inhibit === 1'b1 && busy === 1'b0, "reset state");
        step();
        irq_scenario();
        nmi_scenario();
        reset_scenario();
        complete_run();
    end
endmodule
